// *** hw/hlt_modes.v ***
// Mode control, counter, period compare and PWM drive of the hardware limit timer
`include "hlt_modes_regs.vh"
`default_nettype none

// What this block does
// - Mode 00000 counts while run bit set, stops when software clears it.
// - Modes 00001/00010 count only while run set and external input high/low.
// - Modes 00011/00100/00101 reset counter on any, rising, falling external edge.
// - Modes 00110/00111 hold counter reset while external input low/high.
// - Mode 01000 is a one-shot started by setting the run bit alone.
// - Modes 01001-01011 start one-shot on run set plus rising, falling, any edge.
// - Modes 01100/01101 start and reset on the same edge polarity.
// - Mode 01110 starts rising, resets low; 01111 starts falling, resets high.
// - One-shot period match clears run bit and stops counter at zero.
// - Edge-started modes need a fresh edge after run set before restarting.
// - Monostable modes 10001-10011 start on rising, falling or either edge.
// - Monostable period match stops counter at zero, run bit stays set.
// - Monostable PWM goes active on start edge only; later edges ignored.
// - Modes 10110/10111 hold reset at low/high level; start when run and released.
// - Level one-shot match resets counter, clears run, waits for both again.
// - Level one-shot PWM goes active at whichever event starts the timer.
module hlt_modes #(
   parameter WIDTH = 8
) (
   input  wire             I_CORE_CLK,
   input  wire             I_RST,
   input  wire             I_CE,
   input  wire             I_TICK,
   input  wire             I_RUN_SET,
   input  wire             I_RUN_CLR,
   input  wire [4:0]       I_MODE,
   input  wire [WIDTH-1:0] I_PERIOD_VALUE,
   input  wire [WIDTH-1:0] I_DUTY,
   input  wire             I_EXT_RESET_INPUT,
   output reg  [WIDTH-1:0] O_COUNT_VALUE,
   output reg              O_RUN,
   output reg              O_MATCH,
   output reg              O_PWM
);

   // Timing-class localparams for the mode decoder
   localparam [2:0] CLS_IDLE     = 3'h0;
   localparam [2:0] CLS_FREE     = 3'h1;
   localparam [2:0] CLS_ONESHOT  = 3'h2;
   localparam [2:0] CLS_MONO     = 3'h3;
   localparam [2:0] CLS_LEVEL_OS = 3'h4;

   // Edge selection helper: does the chosen edge kind occur now
   function edge_hit;
      input [1:0] kind;
      input       rise;
      input       fall;
      begin
         case (kind)
            `HLT_EDGE_RISE: edge_hit = rise;
            `HLT_EDGE_FALL: edge_hit = fall;
            `HLT_EDGE_ANY:  edge_hit = rise | fall;
            default:        edge_hit = 1'b0;
         endcase
      end
   endfunction

   // Start edge decode, shared by one-shot and monostable groups
   function [1:0] start_edge_of;
      input [2:0] opt;
      begin
         case (opt)
            `HLT_OPT_1: start_edge_of = `HLT_EDGE_RISE;
            `HLT_OPT_2: start_edge_of = `HLT_EDGE_FALL;
            `HLT_OPT_3: start_edge_of = `HLT_EDGE_ANY;
            `HLT_OPT_4: start_edge_of = `HLT_EDGE_RISE;
            `HLT_OPT_5: start_edge_of = `HLT_EDGE_FALL;
            `HLT_OPT_6: start_edge_of = `HLT_EDGE_RISE;
            `HLT_OPT_7: start_edge_of = `HLT_EDGE_FALL;
            default:    start_edge_of = `HLT_EDGE_NONE;
         endcase
      end
   endfunction

   // Internal state
   reg [WIDTH-1:0] count_reg;
   reg [WIDTH-1:0] count_next;
   reg             run_reg;
   reg             run_next;
   reg             started_reg;
   reg             started_next;
   reg             ext_prev_reg;
   reg             match_next;
   reg             pwm_next;

   // Mode decode results
   reg  [2:0]      cls;
   reg  [1:0]      start_kind;
   reg             gate_en;
   reg             edge_rst;
   reg             level_rst;
   reg             live;
   reg             hw_clear_run;
   reg             start_now;

   wire [1:0]      grp = I_MODE[`HLT_GRP_MSB:`HLT_GRP_LSB];
   wire [2:0]      opt = I_MODE[`HLT_OPT_MSB:`HLT_OPT_LSB];
   wire            ext = I_EXT_RESET_INPUT;
   // Input is synchronous to the core clock, so edges come from one delay stage.
   // History clears to low, so a high input at release reads as a rising edge;
   // that is harmless because the run bit is still clear on that cycle.
   wire            ext_rise = ext & ~ext_prev_reg;
   wire            ext_fall = ~ext & ext_prev_reg;
   // Edges are seen every core clock, so a short pulse between ticks still counts
   // Compare runs every core clock; the match is only acted on with the tick itself
   wire            at_period = (count_reg == I_PERIOD_VALUE);
   wire            tick_match = I_TICK & at_period;

   // Classify the mode into a timing class
   // Reserved codes fall to idle so an unknown code can never run the counter
   always @* begin
      cls = CLS_IDLE;
      case (grp)
         `HLT_GRP_FREE: begin
            cls = CLS_FREE;
         end
         `HLT_GRP_ONESHOT: begin
            cls = CLS_ONESHOT;
         end
         `HLT_GRP_MONO_LVL: begin
            if ((opt == `HLT_OPT_1) || (opt == `HLT_OPT_2) || (opt == `HLT_OPT_3)) begin
               cls = CLS_MONO;
            end else if ((opt == `HLT_OPT_6) || (opt == `HLT_OPT_7)) begin
               cls = CLS_LEVEL_OS;
            end else begin
               cls = CLS_IDLE;
            end
         end
         default: begin
            cls = CLS_IDLE;
         end
      endcase
   end

   // Per-mode gating, reset and start conditions
   always @* begin
      gate_en    = 1'b0;
      edge_rst   = 1'b0;
      level_rst  = 1'b0;
      start_kind = `HLT_EDGE_NONE;
      case (cls)
         CLS_FREE: begin
            case (opt)
               `HLT_OPT_0: gate_en = run_reg;
               `HLT_OPT_1: gate_en = run_reg & ext;
               `HLT_OPT_2: gate_en = run_reg & ~ext;
               `HLT_OPT_3: begin
                  gate_en  = run_reg;
                  edge_rst = ext_rise | ext_fall;
               end
               `HLT_OPT_4: begin
                  gate_en  = run_reg;
                  edge_rst = ext_rise;
               end
               `HLT_OPT_5: begin
                  gate_en  = run_reg;
                  edge_rst = ext_fall;
               end
               `HLT_OPT_6: begin
                  gate_en   = run_reg & ext;
                  level_rst = ~ext;
               end
               default: begin
                  gate_en   = run_reg & ~ext;
                  level_rst = ext;
               end
            endcase
         end
         CLS_ONESHOT: begin
            start_kind = start_edge_of(opt);
            case (opt)
               `HLT_OPT_4: edge_rst = ext_rise;
               `HLT_OPT_5: edge_rst = ext_fall;
               `HLT_OPT_6: level_rst = ~ext;
               `HLT_OPT_7: level_rst = ext;
               default:    edge_rst = 1'b0;
            endcase
         end
         CLS_MONO: begin
            start_kind = start_edge_of(opt);
         end
         CLS_LEVEL_OS: begin
            // Reset level low for option 6, high for option 7
            level_rst = (opt == `HLT_OPT_6) ? ~ext : ext;
            gate_en   = run_reg & ~level_rst;
         end
         default: begin
            gate_en = 1'b0;
         end
      endcase
   end

   // Start detection and the liveness of the count this cycle
   always @* begin
      start_now = 1'b0;
      live      = 1'b0;
      if (cls == CLS_ONESHOT) begin
         if (opt == `HLT_OPT_0) begin
            live = run_reg;
         end else begin
            // Edge only counts while run is already set, so a stale edge is lost
            start_now = run_reg & ~started_reg & edge_hit(start_kind, ext_rise, ext_fall);
            live      = run_reg & (started_reg | start_now) & ~level_rst;
         end
      end else if (cls == CLS_MONO) begin
         // Edges during counting are ignored because started is already set
         start_now = run_reg & ~started_reg & edge_hit(start_kind, ext_rise, ext_fall);
         live      = run_reg & (started_reg | start_now);
      end else begin
         live = gate_en;
      end
   end

   // Counter, started flag and hardware clear of the run bit
   always @* begin
      count_next   = count_reg;
      started_next = started_reg;
      hw_clear_run = 1'b0;
      match_next   = 1'b0;
      case (cls)
         CLS_FREE: begin
            // Free modes never use the start flag; dropping it here stops a
            // stale start from an edge mode being applied after a mode change
            started_next = 1'b0;
            if (level_rst) begin
               count_next = `HLT_COUNT_RST;
            end else if (edge_rst) begin
               count_next = `HLT_COUNT_RST;
            end else if (live && I_TICK) begin
               match_next = at_period;
               count_next = at_period ? `HLT_COUNT_RST : count_reg + 1'b1;
            end
         end
         CLS_ONESHOT, CLS_MONO: begin
            if (!run_reg) begin
               started_next = 1'b0;
            end else if (start_now) begin
               started_next = 1'b1;
            end
            if (level_rst) begin
               count_next   = `HLT_COUNT_RST;
               started_next = 1'b0;
            end else if (edge_rst && started_reg) begin
               count_next = `HLT_COUNT_RST;
            end else if (live && tick_match) begin
               match_next   = 1'b1;
               count_next   = `HLT_COUNT_RST;
               // Monostable keeps the run bit and re-arms for the next edge
               started_next = 1'b0;
               hw_clear_run = (cls == CLS_ONESHOT);
            end else if (live && I_TICK) begin
               count_next = count_reg + 1'b1;
            end
         end
         CLS_LEVEL_OS: begin
            started_next = 1'b0;
            if (level_rst) begin
               count_next = `HLT_COUNT_RST;
            end else if (live && tick_match) begin
               match_next   = 1'b1;
               count_next   = `HLT_COUNT_RST;
               hw_clear_run = 1'b1;
            end else if (live && I_TICK) begin
               count_next = count_reg + 1'b1;
            end else if (!run_reg) begin
               count_next = `HLT_COUNT_RST;
            end
         end
         default: begin
            count_next   = `HLT_COUNT_RST;
            started_next = 1'b0;
         end
      endcase
   end

   // Run bit: software set wins over a hardware clear in the same cycle
   // A late set therefore restarts a one-shot instead of being lost to its match
   always @* begin
      run_next = run_reg;
      if (hw_clear_run) begin
         run_next = 1'b0;
      end
      if (I_RUN_CLR) begin
         run_next = 1'b0;
      end
      if (I_RUN_SET) begin
         run_next = 1'b1;
      end
   end

   // PWM follows the live count; in monostable it stays low after the match
   // Free modes drive PWM from the run bit alone; gating only pauses the count
   always @* begin
      pwm_next = 1'b0;
      if (cls == CLS_MONO) begin
         pwm_next = (started_next | start_now) & (count_next < I_DUTY);
      end else if (cls == CLS_LEVEL_OS) begin
         // Either the release or the run set makes live true, so both start PWM
         pwm_next = live & ~hw_clear_run & (count_next < I_DUTY);
      end else if (cls == CLS_ONESHOT) begin
         pwm_next = live & ~hw_clear_run & (count_next < I_DUTY);
      end else if (cls == CLS_FREE) begin
         pwm_next = run_reg & (count_next < I_DUTY);
      end
   end

   // State registers; the clock enable freezes everything while low.
   // Reset overrides the enable so the block always comes up idle, and the
   // edge history freezes too, so a change during a frozen spell is seen later.
   always @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         count_reg     <= `HLT_COUNT_RST;
         run_reg       <= `HLT_RUN_RST;
         started_reg   <= `HLT_STARTED_RST;
         ext_prev_reg  <= `HLT_EXT_PREV_RST;
         O_COUNT_VALUE <= `HLT_COUNT_RST;
         O_RUN         <= `HLT_RUN_RST;
         O_MATCH       <= 1'b0;
         O_PWM         <= `HLT_PWM_RST;
      end else if (I_CE) begin
         count_reg     <= count_next;
         run_reg       <= run_next;
         started_reg   <= started_next;
         ext_prev_reg  <= ext;
         O_COUNT_VALUE <= count_next;
         O_RUN         <= run_next;
         O_MATCH       <= match_next;
         O_PWM         <= pwm_next;
      end
   end

endmodule

`default_nettype wire

// *** include/hlt_modes_regs.vh ***
// Mode codes, field positions and reset values for the hardware limit timer
`ifndef HLT_MODES_REGS_VH
`define HLT_MODES_REGS_VH

// Mode field layout: upper group bits and lower option bits
`define HLT_GRP_MSB        4
`define HLT_GRP_LSB        3
`define HLT_OPT_MSB        2
`define HLT_OPT_LSB        0

// Mode groups (upper two bits)
`define HLT_GRP_FREE       2'h0
`define HLT_GRP_ONESHOT    2'h1
`define HLT_GRP_MONO_LVL   2'h2
`define HLT_GRP_RSVD       2'h3

// Option codes (lower three bits)
`define HLT_OPT_0          3'h0
`define HLT_OPT_1          3'h1
`define HLT_OPT_2          3'h2
`define HLT_OPT_3          3'h3
`define HLT_OPT_4          3'h4
`define HLT_OPT_5          3'h5
`define HLT_OPT_6          3'h6
`define HLT_OPT_7          3'h7

// Reset values
`define HLT_COUNT_RST      8'h00
`define HLT_RUN_RST        1'h0
`define HLT_STARTED_RST    1'h0
`define HLT_EXT_PREV_RST   1'h0
`define HLT_PWM_RST        1'h0

// Edge selectors used by the start decoder
`define HLT_EDGE_NONE      2'h0
`define HLT_EDGE_RISE      2'h1
`define HLT_EDGE_FALL      2'h2
`define HLT_EDGE_ANY       2'h3

`endif

// *** sim/hlt_modes_monitor.sv ***
// Checker bound to the ports of the timer mode control
`default_nettype none
module hlt_modes_monitor #(
   parameter int WIDTH = 8
) (
   input wire logic             I_CORE_CLK,
   input wire logic             I_RST,
   input wire logic             I_CE,
   input wire logic             I_TICK,
   input wire logic             I_RUN_SET,
   input wire logic             I_RUN_CLR,
   input wire logic [4:0]       I_MODE,
   input wire logic [WIDTH-1:0] I_PERIOD_VALUE,
   input wire logic [WIDTH-1:0] I_DUTY,
   input wire logic             I_EXT_RESET_INPUT,
   input wire logic [WIDTH-1:0] O_COUNT_VALUE,
   input wire logic             O_RUN,
   input wire logic             O_MATCH,
   input wire logic             O_PWM
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge I_CORE_CLK);
   endclocking
   default disable iff (I_RST);
   wire logic rsv;
   // Reserved codes, where the count must stay idle
   assign rsv = I_MODE == 5'h10 || I_MODE == 5'h14 || I_MODE == 5'h15 || I_MODE[4:3] == 2'h3;
   // A tick that the design acted on as a period match
   sequence s_hit;
      (I_CE && I_TICK) ##1 O_MATCH;
   endsequence
   // Idle and match behaviour
   a_rsv_idle: assert property (
      I_CE && rsv |=> O_COUNT_VALUE == '0 && !O_MATCH && !O_PWM) else $error("reserved not idle");
   a_match_period: assert property (
      O_MATCH && $past(I_CE) |-> $past(I_TICK) && $past(O_COUNT_VALUE) == $past(I_PERIOD_VALUE))
      else $error("match without period hit");
   a_oneshot_end: assert property (
      s_hit |-> $past(I_MODE[4:3]) != 2'h1 || $past(I_RUN_SET) || (!O_RUN && O_COUNT_VALUE == '0))
      else $error("one-shot did not stop");
   a_mono_keep: assert property (
      s_hit |-> !($past(I_MODE) inside {5'h11, 5'h12, 5'h13}) || $past(I_RUN_CLR)
         || (O_RUN && O_COUNT_VALUE == '0)) else $error("monostable end wrong");
   // Counting only steps by one on an enabled tick; a frozen cycle changes nothing
   a_count_step: assert property (
      O_COUNT_VALUE != '0 && O_COUNT_VALUE != $past(O_COUNT_VALUE) |-> $past(I_TICK)
         && $past(I_CE) && O_COUNT_VALUE == $past(O_COUNT_VALUE) + 1'b1) else $error("bad step");
   a_ce_freeze: assert property (
      !I_CE |=> $stable(O_COUNT_VALUE) && $stable(O_RUN) && $stable(O_PWM) && $stable(O_MATCH))
      else $error("state moved while frozen");
   // Run bit control, set winning over clear
   a_run_set: assert property (I_CE && I_RUN_SET |=> O_RUN) else $error("run not set");
   a_run_clear: assert property (
      I_CE && I_RUN_CLR && !I_RUN_SET |=> !O_RUN) else $error("run not cleared");
   a_sw_hold: assert property (
      I_CE && I_MODE == 5'h00 && !O_RUN && !I_RUN_SET |=> $stable(O_COUNT_VALUE))
      else $error("counted while stopped");
   // Gate and level reset
   a_gate_hold: assert property (
      I_CE && (I_MODE == 5'h01 && !I_EXT_RESET_INPUT || I_MODE == 5'h02 && I_EXT_RESET_INPUT)
      |=> $stable(O_COUNT_VALUE)) else $error("counted while gated off");
   a_level_hold: assert property (
      I_CE && !I_MODE[3] && I_MODE[2:1] == 2'h3 && I_MODE[0] == I_EXT_RESET_INPUT
      |=> O_COUNT_VALUE == '0) else $error("not held at reset level");
endmodule
bind hlt_modes hlt_modes_monitor #(.WIDTH(WIDTH)) hlt_modes_monitor_inst (
   .I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_CE(I_CE), .I_TICK(I_TICK),
   .I_RUN_SET(I_RUN_SET), .I_RUN_CLR(I_RUN_CLR), .I_MODE(I_MODE),
   .I_PERIOD_VALUE(I_PERIOD_VALUE), .I_DUTY(I_DUTY),
   .I_EXT_RESET_INPUT(I_EXT_RESET_INPUT), .O_COUNT_VALUE(O_COUNT_VALUE),
   .O_RUN(O_RUN), .O_MATCH(O_MATCH), .O_PWM(O_PWM)
);
`default_nettype wire

// *** sim/hlt_ext_model.sv ***
// Far-side model: external reset source and PWM output stage
`default_nettype none
module hlt_ext_model (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_level,
   input  wire logic       i_pwm,
   output wire logic       o_ext,
   output var  logic [7:0] o_rises
);
   timeunit 1ns;
   timeprecision 1ps;
   logic pwm_reg;
   // Source follows the requested level; it is already synchronous to the core
   assign o_ext = i_level;
   // Count PWM activations, so a missing or extra activation shows up
   always @(posedge i_clk) begin
      pwm_reg <= i_pwm;
      if (i_rst)
         o_rises <= 8'h00;
      else if (i_pwm && !pwm_reg)
         o_rises <= o_rises + 8'h01;
   end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the timer mode control
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [4:0] m; logic up; logic [7:0] c;} row_t;
   logic       clk, run, match, pwm, ext;
   logic       rst = 1'h1, ce = 1'h1, tick = 1'h1, rset = 1'h0, rclr = 1'h0, lvl = 1'h0;
   logic [4:0] mode = 5'h00;
   logic [7:0] per = 8'h10, duty = 8'h00, cnt, rises;
   int         n_fail = 0, n_checks = 0;
   // Mode, direction of the external change, count four edges after that change
   row_t       rows [26] = '{
      '{5'h00, 1'h1, 8'h06}, '{5'h01, 1'h1, 8'h04}, '{5'h02, 1'h0, 8'h04}, '{5'h03, 1'h0, 8'h03},
      '{5'h04, 1'h1, 8'h03}, '{5'h05, 1'h0, 8'h03}, '{5'h06, 1'h1, 8'h04}, '{5'h07, 1'h0, 8'h04},
      '{5'h08, 1'h1, 8'h06}, '{5'h09, 1'h1, 8'h04}, '{5'h0a, 1'h0, 8'h04}, '{5'h0b, 1'h0, 8'h04},
      '{5'h0c, 1'h1, 8'h04}, '{5'h0d, 1'h0, 8'h04}, '{5'h0e, 1'h1, 8'h04}, '{5'h0f, 1'h0, 8'h04},
      '{5'h11, 1'h1, 8'h04}, '{5'h12, 1'h0, 8'h04}, '{5'h13, 1'h0, 8'h04}, '{5'h16, 1'h1, 8'h04},
      '{5'h17, 1'h0, 8'h04}, '{5'h10, 1'h1, 8'h00}, '{5'h14, 1'h1, 8'h00}, '{5'h15, 1'h0, 8'h00},
      '{5'h18, 1'h1, 8'h00}, '{5'h1f, 1'h0, 8'h00}};
   hlt_modes #(.WIDTH(8)) hlt_modes_inst (
      .I_CORE_CLK(clk), .I_RST(rst), .I_CE(ce), .I_TICK(tick), .I_RUN_SET(rset),
      .I_RUN_CLR(rclr), .I_MODE(mode), .I_PERIOD_VALUE(per), .I_DUTY(duty),
      .I_EXT_RESET_INPUT(ext), .O_COUNT_VALUE(cnt), .O_RUN(run), .O_MATCH(match), .O_PWM(pwm));
   hlt_ext_model hlt_ext_model_inst (
      .i_clk(clk), .i_rst(rst), .i_level(lvl), .i_pwm(pwm), .o_ext(ext), .o_rises(rises));
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmp1(input string what, input logic exp, input logic got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Reset for two cycles, then let the edge history settle with run clear
   task automatic do_reset(input logic [4:0] m, input logic e);
      mode = m;
      lvl = e;
      rst = 1'h1;
      step(2);
      rst = 1'h0;
      step(2);
   endtask
   // One-cycle software pulse on the run set or clear input
   task automatic pulse(input logic clr);
      if (clr)
         rclr = 1'h1;
      else
         rset = 1'h1;
      step(1);
      rclr = 1'h0;
      rset = 1'h0;
   endtask
   // Bounded wait; a hang is counted and ends the run
   task automatic wait_match();
      int k;
      k = 0;
      while (match !== 1'h1 && k < 50) begin
         step(1);
         k++;
      end
      if (match !== 1'h1) begin
         n_fail++;
         $display("unexpected timeout expected match seen none");
         final_report();
      end
   endtask
   initial begin
      step(1);
      foreach (rows[i]) begin
         do_reset(rows[i].m, !rows[i].up);
         pulse(1'h0);
         step(2);
         lvl = rows[i].up;
         step(4);
         cmp8("count", rows[i].c, cnt);
         cmp1("run", 1'h1, run);
      end
      // One-shot end at the period match
      per = 8'h03;
      do_reset(5'h08, 1'h0);
      pulse(1'h0);
      step(3);
      cmp8("count", 8'h03, cnt);
      step(1);
      cmp1("match", 1'h1, match);
      cmp1("run", 1'h0, run);
      step(2);
      cmp8("count", 8'h00, cnt);
      // Freeze, missing ticks and software stop all hold the count
      per = 8'h10;
      do_reset(5'h00, 1'h0);
      pulse(1'h0);
      step(2);
      ce = 1'h0;
      step(3);
      ce = 1'h1;
      tick = 1'h0;
      step(2);
      pulse(1'h1);
      tick = 1'h1;
      step(3);
      cmp8("count", 8'h02, cnt);
      cmp1("run", 1'h0, run);
      // Edge seen while run was clear must not start
      do_reset(5'h09, 1'h0);
      lvl = 1'h1;
      step(2);
      pulse(1'h0);
      step(3);
      cmp8("count", 8'h00, cnt);
      lvl = 1'h0;
      step(1);
      lvl = 1'h1;
      step(2);
      cmp8("count", 8'h02, cnt);
      // Monostable with an extra edge mid-count, then a restart
      per = 8'h03;
      duty = 8'h02;
      do_reset(5'h11, 1'h0);
      pulse(1'h0);
      lvl = 1'h1;
      step(1);
      lvl = 1'h0;
      step(1);
      lvl = 1'h1;
      step(1);
      cmp8("count", 8'h03, cnt);
      step(1);
      cmp1("match", 1'h1, match);
      cmp1("run", 1'h1, run);
      cmp8("pwm starts", 8'h01, rises);
      lvl = 1'h0;
      step(1);
      lvl = 1'h1;
      step(1);
      cmp8("count", 8'h01, cnt);
      // Same-polarity edge resets a running one-shot, the reset level holds it
      per = 8'h10;
      do_reset(5'h0c, 1'h0);
      pulse(1'h0);
      lvl = 1'h1;
      step(3);
      lvl = 1'h0;
      step(1);
      lvl = 1'h1;
      step(2);
      cmp8("count", 8'h01, cnt);
      do_reset(5'h0e, 1'h0);
      pulse(1'h0);
      lvl = 1'h1;
      step(2);
      lvl = 1'h0;
      step(2);
      cmp8("count", 8'h00, cnt);
      per = 8'h03;
      // Level one-shot started by run set, then by the input leaving reset level
      do_reset(5'h16, 1'h1);
      pulse(1'h0);
      wait_match();
      cmp1("run", 1'h0, run);
      cmp8("pwm starts", 8'h01, rises);
      step(2);
      cmp8("count", 8'h00, cnt);
      lvl = 1'h0;
      pulse(1'h0);
      step(2);
      cmp8("count", 8'h00, cnt);
      lvl = 1'h1;
      step(2);
      cmp8("count", 8'h02, cnt);
      cmp8("pwm starts", 8'h02, rises);
      // Reset in mid-count clears everything
      rst = 1'h1;
      step(1);
      cmp8("count", 8'h00, cnt);
      cmp1("run", 1'h0, run);
      rst = 1'h0;
      step(2);
      final_report();
   end
endmodule
`default_nettype wire
